// ### hdl/cff_pkg.sv
// Package with register map, field positions and reset values for the CAN FIFO status flags
package cff_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses, word index in address bits 3:2)
    localparam logic [3:0] CFF_OFS_FLAGS   = 4'h0;
    localparam logic [3:0] CFF_OFS_CONTROL = 4'h4;
    localparam logic [3:0] CFF_OFS_LEVEL   = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in can_fifo_event_flags
    localparam int CFF_BIT_TX_HALF   = 9;
    localparam int CFF_BIT_TX_EMPTY  = 8;
    localparam int CFF_BIT_RX_OVR    = 3;
    localparam int CFF_BIT_RX_FULL   = 2;
    localparam int CFF_BIT_RX_HALF   = 1;
    localparam int CFF_BIT_RX_NEMPTY = 0;

    // Field positions in control register
    localparam int CFF_BIT_DIR_TX    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic       CFF_RST_DIR_TX = 1'b0;
    localparam logic [31:0] CFF_RST_RDATA = 32'h0000_0000;
    localparam logic [31:0] CFF_UNMAPPED  = 32'h0000_0000;

    // Default depth of the message FIFO
    localparam int CFF_DEF_DEPTH = 32;

endpackage

// ### hdl/cff_level_flags.sv
// Level flag decoder for one CAN message FIFO
`timescale 1ns/1ps
module cff_level_flags #(
    parameter int DEPTH = 32,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Configuration and occupancy
    input  wire logic          dir_tx_in,
    input  wire logic [CW-1:0] count_in,
    // Live flags
    output logic               tx_half_out,
    output logic               tx_empty_out,
    output logic               rx_full_out,
    output logic               rx_half_out,
    output logic               rx_nempty_out
);
    localparam logic [CW+1:0] DEPTH_W = (CW+2)'(DEPTH);

    // Compare twice the count with depth so odd depths round correctly
    wire logic [CW+1:0] twice_count = {1'b0, count_in, 1'b0};
    wire logic          is_empty    = (count_in == '0);
    wire logic          at_most_half = (twice_count <= DEPTH_W);
    wire logic          at_least_half = (twice_count >= DEPTH_W);
    wire logic          is_full     = ({2'b00, count_in} == DEPTH_W);

    assign tx_half_out   = dir_tx_in & at_most_half;
    assign tx_empty_out  = dir_tx_in & is_empty;
    assign rx_full_out   = ~dir_tx_in & is_full;
    assign rx_half_out   = ~dir_tx_in & at_least_half;
    assign rx_nempty_out = ~dir_tx_in & ~is_empty;
endmodule

// ### hdl/cff_status_top.sv
// Status flag block for one CAN message FIFO with Avalon-MM register slave
`timescale 1ns/1ps
module cff_status_top
    import cff_pkg::*;
#(
    parameter int DEPTH = cff_pkg::CFF_DEF_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          sys_rst_in,
    // FIFO events from the message engine
    input  wire logic          push_in,
    input  wire logic          pop_in,
    // Avalon-MM slave
    input  wire logic [3:0]    avs_address_in,
    input  wire logic          avs_read_in,
    input  wire logic          avs_write_in,
    input  wire logic [31:0]   avs_writedata_in,
    input  wire logic [3:0]    avs_byteenable_in,
    output logic [31:0]        avs_readdata_out,
    output logic               avs_waitrequest_out,
    // Status outputs
    output logic               fifo_direction_transmit_out,
    output logic [CW-1:0]      fifo_count_out,
    output logic               rx_overrun_flag_out
);
    import cff_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake states, one-hot; an illegal code falls back to idle
    typedef enum logic [1:0] {
        CFF_BUS_IDLE = 2'b01,
        CFF_BUS_ACK  = 2'b10
    } cff_bus_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // State
    cff_bus_state_e bus_state;
    cff_bus_state_e next_bus_state;
    logic           fifo_direction_transmit;
    logic [CW-1:0]  count;
    logic           rx_overrun_flag;
    logic [31:0]    rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire logic bus_idle  = (bus_state == CFF_BUS_IDLE);
    wire logic req       = (avs_read_in | avs_write_in) & bus_idle;
    wire logic rd_req    = req & avs_read_in;
    wire logic wr_req    = req & avs_write_in;
    wire logic sel_flags = (avs_address_in == CFF_OFS_FLAGS);
    wire logic sel_ctrl  = (avs_address_in == CFF_OFS_CONTROL);
    wire logic sel_level = (avs_address_in == CFF_OFS_LEVEL);
    wire logic wr_flags  = wr_req & sel_flags & avs_byteenable_in[0];
    wire logic wr_ctrl   = wr_req & sel_ctrl & avs_byteenable_in[0];

    ////////////////////////////////////////////////////////////////////////////
    // Direction: a control write with the low byte enabled sets it
    wire logic next_direction = wr_ctrl ? avs_writedata_in[CFF_BIT_DIR_TX]
                                        : fifo_direction_transmit;

    ////////////////////////////////////////////////////////////////////////////
    // Occupancy
    wire logic          is_full    = ({1'b0, count} == (CW+1)'(DEPTH));
    wire logic          is_empty   = (count == '0);
    wire logic          do_push    = push_in & ~is_full;
    wire logic          do_pop     = pop_in & ~is_empty;
    wire logic          count_up   = do_push & ~do_pop;
    wire logic          count_down = do_pop & ~do_push;
    wire logic [CW-1:0] count_inc  = count + CW'(1);
    wire logic [CW-1:0] count_dec  = count - CW'(1);
    // Any control write with the low byte enabled resets occupancy: the FIFO is reconfigured empty
    wire logic [CW-1:0] next_count = wr_ctrl    ? '0 :
                                     count_up   ? count_inc :
                                     count_down ? count_dec : count;

    ////////////////////////////////////////////////////////////////////////////
    // Overrun: a receive message arriving with no room; set wins over clear
    wire logic rx_dir       = ~fifo_direction_transmit;
    wire logic no_room      = push_in & is_full & ~do_pop;
    wire logic overrun_evt  = rx_dir & no_room;
    wire logic ovr_clr      = wr_flags & ~avs_writedata_in[CFF_BIT_RX_OVR];
    wire logic ovr_keep     = rx_overrun_flag & ~ovr_clr & ~wr_ctrl;
    wire logic next_overrun = overrun_evt | ovr_keep;

    ////////////////////////////////////////////////////////////////////////////
    // Live flags
    logic tx_half_vacant_flag;
    logic tx_drained_flag;
    logic rx_saturated_flag;
    logic rx_half_occupied_flag;
    logic rx_has_message_flag;

    cff_level_flags #(
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_flags (
        .dir_tx_in     (fifo_direction_transmit),
        .count_in      (count),
        .tx_half_out   (tx_half_vacant_flag),
        .tx_empty_out  (tx_drained_flag),
        .rx_full_out   (rx_saturated_flag),
        .rx_half_out   (rx_half_occupied_flag),
        .rx_nempty_out (rx_has_message_flag)
    );

    // Overrun bit masked in transmit direction
    wire logic ovr_view = rx_overrun_flag & ~fifo_direction_transmit;

    // Level flags are not writable: only the overrun bit takes a write
    wire logic [31:0] can_fifo_event_flags = 32'h0000_0000
        | (32'(tx_half_vacant_flag)   << CFF_BIT_TX_HALF)
        | (32'(tx_drained_flag)       << CFF_BIT_TX_EMPTY)
        | (32'(ovr_view)              << CFF_BIT_RX_OVR)
        | (32'(rx_saturated_flag)     << CFF_BIT_RX_FULL)
        | (32'(rx_half_occupied_flag) << CFF_BIT_RX_HALF)
        | (32'(rx_has_message_flag)   << CFF_BIT_RX_NEMPTY);

    wire logic [31:0] ctrl_view  = 32'(fifo_direction_transmit) << CFF_BIT_DIR_TX;
    wire logic [31:0] level_view = 32'(count);
    wire logic [31:0] next_rdata = sel_flags ? can_fifo_event_flags :
                                   sel_ctrl  ? ctrl_view :
                                   sel_level ? level_view : CFF_UNMAPPED;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake sequencing
    always_comb begin
        next_bus_state = CFF_BUS_IDLE;
        unique case (bus_state)
            CFF_BUS_IDLE: begin
                next_bus_state = req ? CFF_BUS_ACK : CFF_BUS_IDLE;
            end
            CFF_BUS_ACK: begin
                next_bus_state = CFF_BUS_IDLE;
            end
            default: begin
                next_bus_state = CFF_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            bus_state <= CFF_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and occupancy registers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fifo_direction_transmit <= CFF_RST_DIR_TX;
        end else begin
            fifo_direction_transmit <= next_direction;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Event flag: held until software clears it, no overrun is lost
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rx_overrun_flag <= 1'b0;
        end else begin
            rx_overrun_flag <= next_overrun;
        end
    end

    // Read data captured at the taking edge, held until the next read
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rdata <= CFF_RST_RDATA;
        end else if (rd_req) begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop
    // One wait cycle per access; registered read data stand at release
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= CFF_RST_RDATA;
        end else begin
            avs_readdata_out <= rd_req ? next_rdata : rdata;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~req;
        end
    end

    // Status copies lag the internal state by one cycle
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fifo_direction_transmit_out <= CFF_RST_DIR_TX;
        end else begin
            fifo_direction_transmit_out <= fifo_direction_transmit;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            fifo_count_out <= '0;
        end else begin
            fifo_count_out <= count;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rx_overrun_flag_out <= 1'b0;
        end else begin
            rx_overrun_flag_out <= ovr_view;
        end
    end
endmodule

// ### tb/cff_status_checker.sv
// Port checker for the CAN FIFO status flag block
`timescale 1ns/1ps
module cff_status_checker #(
    parameter int DEPTH = 32,
    parameter int CW    = 6
) (
    input wire logic          clock_in, sys_rst_in, push_in, pop_in,
    input wire logic [3:0]    avs_address_in, avs_byteenable_in,
    input wire logic          avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire logic [31:0]   avs_writedata_in, avs_readdata_out,
    input wire logic          fifo_direction_transmit_out, rx_overrun_flag_out,
    input wire logic [CW-1:0] fifo_count_out
);
    ////////////////////////////////////////
    // Count output lags, so flags are judged only after quiet cycles
    logic [2:0] qh;
    wire        dx = fifo_direction_transmit_out;
    wire [31:0] cn = 32'(fifo_count_out);
    wire [31:0] f  = avs_readdata_out;
    wire        rd = avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0 && (&qh);
    always_ff @(posedge clock_in) qh <= sys_rst_in ? 3'h0 : {qh[1:0], !push_in && !pop_in};
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    property p_txh; rd |-> f[9] == (dx && 2 * cn <= DEPTH); endproperty
    a_txh: assert property (p_txh) else $error("tx half flag wrong");
    property p_txe; rd |-> f[8] == (dx && cn == 0); endproperty
    a_txe: assert property (p_txe) else $error("tx empty flag wrong");
    property p_ful; rd |-> f[2] == (!dx && cn == DEPTH); endproperty
    a_ful: assert property (p_ful) else $error("rx full flag wrong");
    property p_hlf; rd |-> f[1] == (!dx && 2 * cn >= DEPTH); endproperty
    a_hlf: assert property (p_hlf) else $error("rx half flag wrong");
    property p_nem; rd |-> f[0] == (!dx && cn != 0); endproperty
    a_nem: assert property (p_nem) else $error("rx not empty flag wrong");
    property p_ovs; rd |-> f[3] == (!dx && rx_overrun_flag_out); endproperty
    a_ovs: assert property (p_ovs) else $error("overrun bit wrong");
    property p_ovr; (&qh) && push_in && !pop_in && !dx && cn == DEPTH && !avs_write_in
        |-> ##[1:2] rx_overrun_flag_out; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not set");
    property p_hld; rx_overrun_flag_out && !avs_write_in && !$past(avs_write_in)
        |=> rx_overrun_flag_out; endproperty
    a_hld: assert property (p_hld) else $error("overrun lost");
    c_tx: cover property (rd && dx);
    c_rx: cover property (rd && !dx && cn != 0);
    c_ov: cover property ($rose(rx_overrun_flag_out));
endmodule
bind cff_status_top cff_status_checker #(.DEPTH(DEPTH), .CW(CW)) u_chk (.clock_in, .sys_rst_in,
    .push_in, .pop_in, .avs_address_in, .avs_byteenable_in, .avs_read_in, .avs_write_in,
    .avs_waitrequest_out, .avs_writedata_in, .avs_readdata_out, .fifo_direction_transmit_out,
    .rx_overrun_flag_out, .fifo_count_out);

// ### tb/cff_status_top_tb.sv
// Testbench for the CAN FIFO status flag block
`timescale 1ns/1ps
module cff_status_top_tb;
    import cff_pkg::*;
    localparam int D = 4;
    logic        clock_in = 0, sys_rst_in = 1, push_in = 0, pop_in = 0;
    logic        avs_read_in = 0, avs_write_in = 0, dir = 0, ovr = 0;
    logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
    logic        avs_waitrequest_out, fifo_direction_transmit_out, rx_overrun_flag_out;
    logic [2:0]  fifo_count_out;
    int          err_total = 0, checks_done = 0, cyc = 0, cnt = 0, i;
    wire [4:0]   st = {fifo_direction_transmit_out, rx_overrun_flag_out, fifo_count_out};
    cff_status_top #(.DEPTH(D)) u_dut (.clock_in, .sys_rst_in, .push_in, .pop_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .fifo_direction_transmit_out,
        .fifo_count_out, .rx_overrun_flag_out);
    initial forever #5 clock_in = ~clock_in;
    ////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] flags();
        flags = 32'h0;
        if (dir) flags[9:8] = {cnt * 2 <= D, cnt == 0};
        else flags[3:0] = {ovr, cnt == D, cnt * 2 >= D, cnt != 0};
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= w;
        avs_read_in <= !w;
        do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rdf;
        repeat (2) @(posedge clock_in);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, flags());
        chk(32'(st), 32'({dir, ovr & !dir, 3'(cnt)}));
    endtask
    // Push or pop never together, as that corner is left open
    task automatic step(input int o);
        push_in <= (o == 1);
        pop_in <= (o == 2);
        @(posedge clock_in);
        push_in <= 1'b0;
        pop_in <= 1'b0;
        if (o == 1 && cnt < D) cnt++;
        else if (o == 1 && !dir) ovr = 1'b1;
        if (o == 2 && cnt > 0) cnt--;
    endtask
    task automatic rnd;
        repeat (50) begin
            step($urandom_range(2));
            rdf();
        end
        $display("random traffic test done");
    endtask
    initial begin
        void'($urandom(71766));
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        for (i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i * 4), 32'h0, 4'hF);
            chk(q, 32'h0);
        end
        $display("reset value test done");
        for (i = 0; i <= D + 1; i++) begin
            rdf();
            step(1);
        end
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
        rdf();
        bus(1'b1, 4'h0, 32'h0, 4'h0);
        rdf();
        bus(1'b1, 4'h0, 32'h0, 4'hF);
        ovr = 1'b0;
        rdf();
        bus(1'b0, 4'h8, 32'h0, 4'hF);
        chk(q, 32'(cnt));
        $display("receive fill test done");
        rnd();
        bus(1'b1, 4'h4, 32'h1, 4'hF);
        dir = 1'b1;
        cnt = 0;
        ovr = 1'b0;
        bus(1'b0, 4'h4, 32'h0, 4'hF);
        chk(q, 32'h1);
        for (i = 0; i <= D; i++) begin
            rdf();
            step(1);
        end
        $display("transmit fill test done");
        rnd();
        summarize();
    end
endmodule
